//--- tb/bors_sequencer_props.sv
// Checker for the brown-out reset sequencer ports.
// Assumes it is bound to bors_sequencer and runs on the APB clock.
`timescale 1ns/10ps
`default_nettype none
module bors_sequencer_props
  import bors_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Supply and PLL
  input wire logic brownout_n,
  input wire logic pll_lock,
  // Reset and clock control
  input wire logic device_reset_pulse,
  input wire logic internal_reset,
  input wire logic sysclk_hold,
  input wire logic [2:0] clk_source,
  input wire logic pll_enable,
  input wire logic irq
);
  logic seq_r;
  logic [16:0] cnt_r;
  logic [7:0] plen_r;

  // Counts how many cycles the reset pulse has stood so far.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plen_r <= 8'h00;
    end else if (device_reset_pulse) begin
      plen_r <= plen_r + 8'h01;
    end else begin
      plen_r <= 8'h00;
    end
  end

  // Counts the cycles from the reset pulse to the internal reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= 1'b0;
      cnt_r <= '0;
    end else if (!internal_reset) begin
      seq_r <= 1'b0;
    end else if (device_reset_pulse && !seq_r) begin
      seq_r <= 1'b1;
      cnt_r <= '0;
    end else if (seq_r) begin
      cnt_r <= cnt_r + 17'h00001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pulse_len;
    $fell(device_reset_pulse) |-> plen_r == 8'(BORS_RESET_PULSE_CYC);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse length wrong");
  property p_bo_resp;
    $fell(brownout_n) |-> ##[2:6] device_reset_pulse;
  endproperty
  a_bo_resp: assert property (p_bo_resp)
    else $error("no reset pulse after brown-out");
  property p_pulse_ctx;
    device_reset_pulse |-> internal_reset && sysclk_hold;
  endproperty
  a_pulse_ctx: assert property (p_pulse_ctx)
    else $error("reset pulse without held clock and reset");
  property p_lock;
    pll_enable && !pll_lock |-> sysclk_hold;
  endproperty
  a_lock: assert property (p_lock)
    else $error("clock released before lock");
  property p_release;
    $fell(internal_reset) |-> !sysclk_hold && !device_reset_pulse;
  endproperty
  a_release: assert property (p_release)
    else $error("reset released while clock held");
  property p_min_delay;
    $fell(internal_reset) && seq_r |-> cnt_r >= BORS_POWERUP_DELAY_CYC;
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("reset released before power-up delay");
  property p_src_stable;
    !internal_reset |-> $stable(clk_source);
  endproperty
  a_src_stable: assert property (p_src_stable)
    else $error("clock source changed outside reset");
  property p_pll_src;
    pll_enable |-> clk_source == BORS_OSC_SEL_PRI_PLL;
  endproperty
  a_pll_src: assert property (p_pll_src)
    else $error("PLL enabled without PLL source");
  property p_pready;
    psel && !penable |=> pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("no ready in access phase");

  c_pulse: cover property ($rose(device_reset_pulse));
  c_release: cover property ($fell(internal_reset) && seq_r);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule

bind bors_sequencer bors_sequencer_props i_props (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .brownout_n, .pll_lock, .device_reset_pulse, .internal_reset, .sysclk_hold,
  .clk_source, .pll_enable, .irq);
`default_nettype wire

//--- tb/bors_sequencer_tb.sv
// Self-checking bench for the brown-out reset sequencer.
// Assumes the package, the design and the supply model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module bors_sequencer_tb;
  import bors_pkg::*;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask; logic err;} bors_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sleep_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] lock_delay = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, brownout_n, pll_lock, device_reset_pulse, internal_reset;
  logic sysclk_hold, osc_enable, pll_enable, irq;
  logic [2:0] clk_source;
  logic [31:0] rnd = 32'hE32634ED;
  logic [31:0] cfg_tab [3] = '{32'h00000003, 32'h00000112, 32'h00000030};
  bors_note_t notes [$];
  bors_note_t nt;
  int miscompares = 0;
  int compares = 0;
  int cyc, dly;
  logic hold_mid, osc_mid;

  always #5 pclk = ~pclk;

  bors_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .brownout_n, .pll_lock, .sleep_mode, .idle_mode, .device_reset_pulse,
    .internal_reset, .sysclk_hold, .clk_source, .osc_enable, .pll_enable, .irq);
  bors_supply_model i_sup (.pclk, .presetn, .pll_enable, .lock_delay, .brownout_n, .pll_lock);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic timeout_stop();
    miscompares++;
    $display("mismatch at %0t: wait timed out", $time);
    report_and_stop();
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_apb(input logic [31:0] got, input logic err, input bors_note_t n);
    compares++;
    if ((got & n.mask) !== n.exp || err !== n.err) begin
      miscompares++;
      $display("mismatch at %0t: read %h err %b expected %h", $time, got, err, n.exp);
    end
  endtask

  // Each completed transfer is checked against the oldest noted expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      nt = notes.pop_front();
      cmp_apb(prdata, pslverr, nt);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input logic err);
    int n;
    notes.push_back('{e, m, err});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout_stop();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h00000000, 32'h00000000, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, m, e, 1'b0);
  endtask

  // Dips the supply and counts cycles from the reset pulse to the release.
  task automatic run_seq(input int len);
    int n;
    fork
      i_sup.dip(len);
    join_none
    n = 0;
    while (device_reset_pulse !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 40) timeout_stop();
    end
    cyc = 0;
    while (internal_reset !== 1'b0) begin
      @(posedge pclk);
      cyc++;
      if (cyc == 500) begin
        hold_mid = sysclk_hold;
        osc_mid = osc_enable;
      end
      if (cyc > 60000) timeout_stop();
    end
    @(posedge pclk);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(BORS_CONFIG_OFS, 32'h00000137, {26'h0, BORS_POSC_MODE_RST, 1'b0, BORS_OSC_SEL_RST});
    rd(BORS_RESET_CONTROL_REG_OFS, 32'h00000002, 32'h00000000);
    rd(BORS_IRQ_MASK_OFS, 32'h00000003, {30'h0, BORS_IRQ_MASK_RST});
    apb(1'b0, 8'h18, 32'h00000000, 32'h00000000, 32'h00000000, 1'b1);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr_next(rnd);
      lock_delay <= rnd[7:0];
      sleep_mode <= (k == 2) | rnd[9];
      idle_mode <= rnd[8];
      wr(BORS_CONFIG_OFS, cfg_tab[k]);
      run_seq(4 + int'(rnd[2:0]));
      dly = (k == 1) ? BORS_FAILSAFE_DELAY_CYC : BORS_POWERUP_DELAY_CYC;
      cmp_val({31'h0, cyc >= dly && cyc <= dly + 64}, 32'h00000001);
      cmp_val({29'h0, clk_source}, {29'h0, cfg_tab[k][2:0]});
      if (k == 1) cmp_val({30'h0, hold_mid, osc_mid}, 32'h00000003);
      if (k == 0) rd(BORS_OSC_CONTROL_REG_OFS, 32'h00000027, 32'h00000023);
      rd(BORS_RESET_CONTROL_REG_OFS, 32'h00000002, 32'h00000002);
      wr(BORS_RESET_CONTROL_REG_OFS, 32'h00000000);
      rd(BORS_RESET_CONTROL_REG_OFS, 32'h00000002, 32'h00000000);
    end
    rd(BORS_IRQ_STATUS_OFS, 32'h00000003, 32'h00000003);
    wr(BORS_IRQ_MASK_OFS, {rnd[31:2], 2'b01});
    @(posedge pclk);
    cmp_val({31'h0, irq}, 32'h00000001);
    wr(BORS_IRQ_MASK_OFS, 32'h00000000);
    @(posedge pclk);
    cmp_val({31'h0, irq}, 32'h00000000);
    wr(BORS_IRQ_MASK_OFS, 32'h00000003);
    wr(BORS_IRQ_STATUS_OFS, 32'h00000003);
    @(posedge pclk);
    cmp_val({31'h0, irq}, 32'h00000000);
    rd(BORS_IRQ_STATUS_OFS, 32'h00000003, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- tb/bors_supply_model.sv
// Model of the supply monitor and the PLL facing the sequencer.
// Assumes the bench calls dip() just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module bors_supply_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From the sequencer and bench
  input wire logic pll_enable,
  input wire logic [7:0] lock_delay,
  // To the sequencer
  output logic brownout_n,
  output logic pll_lock
);
  logic [7:0] lock_cnt_r;

  // The PLL locks a set number of cycles after it is enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r <= 8'h00;
      pll_lock <= 1'b0;
    end else if (!pll_enable) begin
      lock_cnt_r <= 8'h00;
      pll_lock <= 1'b0;
    end else if (lock_cnt_r == lock_delay) begin
      pll_lock <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + 8'h01;
    end
  end

  initial brownout_n = 1'b1;

  task automatic dip(input int len);
    brownout_n <= 1'b0;
    repeat (len) @(posedge pclk);
    brownout_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- verilog/bors_pkg.sv
// Constants for the brown-out reset sequencer: register map, field positions,
// reset values and timing counts.
// Assumes a 100 MHz APB clock.
package bors_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BORS_RESET_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] BORS_OSC_CONTROL_REG_OFS = 8'h04;
  localparam logic [7:0] BORS_CONFIG_OFS = 8'h08;
  localparam logic [7:0] BORS_IRQ_STATUS_OFS = 8'h0C;
  localparam logic [7:0] BORS_IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] BORS_SEQ_STATUS_OFS = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BORS_BROWNOUT_FLAG_BIT = 1;
  localparam int BORS_PLL_LOCK_BIT = 5;
  localparam int BORS_OSC_SEL_LSB = 0;
  localparam int BORS_POSC_MODE_LSB = 4;
  localparam int BORS_POWERUP_TIMER_ZERO_BIT = 8;
  localparam int BORS_IRQ_BROWNOUT_BIT = 0;
  localparam int BORS_IRQ_RELEASE_BIT = 1;

  // ---------------------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BORS_OSC_SEL_RST = 3'h0;
  localparam logic [1:0] BORS_POSC_MODE_RST = 2'h3;
  localparam logic [1:0] BORS_POSC_MODE_OFF = 2'h3;
  localparam logic [2:0] BORS_OSC_SEL_PRI = 3'h2;
  localparam logic [2:0] BORS_OSC_SEL_PRI_PLL = 3'h3;
  localparam logic [1:0] BORS_POSC_MODE_EC = 2'h0;
  localparam logic [1:0] BORS_IRQ_MASK_RST = 2'h0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int BORS_CLK_MHZ = 100;
  localparam int BORS_RESET_PULSE_NS = 100;
  localparam int BORS_RESET_PULSE_CYC =
    (BORS_RESET_PULSE_NS * BORS_CLK_MHZ + 999) / 1000;
  localparam int BORS_OST_CYCLES = 1024;
  localparam int BORS_POWERUP_DELAY_US = 64;
  localparam int BORS_POWERUP_DELAY_CYC = BORS_POWERUP_DELAY_US * BORS_CLK_MHZ;
  localparam int BORS_FAILSAFE_DELAY_US = 500;
  localparam int BORS_FAILSAFE_DELAY_CYC = BORS_FAILSAFE_DELAY_US * BORS_CLK_MHZ;
  localparam int BORS_CNT_W = 16;

endpackage

//--- verilog/bors_sequencer.sv
// Brown-out reset sequencer with APB register access and one interrupt.
// Assumes brownout_n comes from an asynchronous supply monitor and pll_lock
// from the PLL; both are synchronised here.
//
// Contract
// R1 - A brown-out report produces a reset pulse for the whole device.
// R2 - Clock source follows oscillator select and primary oscillator mode fields.
// R3 - Oscillator mode starts start-up timer; system clock withheld until expiry.
// R4 - With PLL, system clock withheld until lock bit 5 reads one.
// R5 - Power-up delay runs concurrently; internal reset held until it elapses.
// R6 - Zero power-up delay with crystal uses fail-safe monitor delay instead.
// R7 - Every brown-out reset sets flag bit 1 of reset control register.
// R8 - Detection stays active in Sleep and Idle modes.
// R9 - Software clears the brown-out flag after reading it.
`timescale 1ns/10ps
`default_nettype none
module bors_sequencer
  import bors_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Supply monitor and oscillator
  input wire logic brownout_n,
  input wire logic pll_lock,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  // Reset and clock control
  output logic device_reset_pulse,
  output logic internal_reset,
  output logic sysclk_hold,
  output logic [2:0] clk_source,
  output logic osc_enable,
  output logic pll_enable,
  // Interrupt
  output logic irq
);

  typedef enum logic [2:0] {
    S_RUN = 3'b000,
    S_PULSE = 3'b001,
    S_WAIT = 3'b010
  } bors_state_t;

  // Synchronisers.
  logic [1:0] bo_sync_r;
  logic [1:0] lock_sync_r;
  logic bo_prev_r;
  logic brownout_event;

  // Registers.
  logic brownout_flag_r;
  logic [2:0] osc_sel_r;
  logic [1:0] posc_mode_r;
  logic powerup_timer_zero_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;

  // Sequencer.
  bors_state_t state_r;
  logic [7:0] pulse_cnt_r;
  logic [2:0] latched_sel_r;
  logic [1:0] latched_mode_r;
  logic use_osc_r;
  logic use_pll_r;
  logic osc_ok_r;
  logic release_event;
  logic tim_start;
  logic [15:0] ost_load;
  logic [15:0] dly_load;
  logic ost_running;
  logic ost_expired;
  logic dly_running;
  logic dly_expired;

  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Decodes whether the selected source needs the primary oscillator.
  function automatic logic needs_osc(input logic [2:0] sel, input logic [1:0] mode);
    needs_osc = (sel == BORS_OSC_SEL_PRI || sel == BORS_OSC_SEL_PRI_PLL) &&
                (mode != BORS_POSC_MODE_OFF);
  endfunction

  // Decodes whether the selected source runs through the PLL.
  function automatic logic needs_pll(input logic [2:0] sel);
    needs_pll = (sel == BORS_OSC_SEL_PRI_PLL);
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // The monitor is not gated by sleep or idle, so detection runs in every mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_sync_r <= 2'b11;
      bo_prev_r <= 1'b1;
    end else begin
      bo_sync_r <= {bo_sync_r[0], brownout_n}; // R8
      bo_prev_r <= bo_sync_r[1];
    end
  end

  // Lock is only read through its second stage, never the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_sync_r <= 2'b00;
    end else begin
      lock_sync_r <= {lock_sync_r[0], pll_lock};
    end
  end

  assign brownout_event = bo_prev_r && !bo_sync_r[1];

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  // Read data is latched at the setup edge; a write acts on the access edge,
  // the one cycle in which pready stands high.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == BORS_RESET_CONTROL_REG_OFS) ||
                   (paddr == BORS_OSC_CONTROL_REG_OFS) ||
                   (paddr == BORS_CONFIG_OFS) ||
                   (paddr == BORS_IRQ_STATUS_OFS) ||
                   (paddr == BORS_IRQ_MASK_OFS) ||
                   (paddr == BORS_SEQ_STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        BORS_RESET_CONTROL_REG_OFS: prdata[BORS_BROWNOUT_FLAG_BIT] <= brownout_flag_r;
        BORS_OSC_CONTROL_REG_OFS: begin
          prdata[BORS_PLL_LOCK_BIT] <= lock_sync_r[1];
          prdata[BORS_OSC_SEL_LSB +: 3] <= latched_sel_r;
        end
        BORS_CONFIG_OFS: begin
          prdata[BORS_OSC_SEL_LSB +: 3] <= osc_sel_r;
          prdata[BORS_POSC_MODE_LSB +: 2] <= posc_mode_r;
          prdata[BORS_POWERUP_TIMER_ZERO_BIT] <= powerup_timer_zero_r;
        end
        BORS_IRQ_STATUS_OFS: prdata[1:0] <= irq_status_r;
        BORS_IRQ_MASK_OFS: prdata[1:0] <= irq_mask_r;
        BORS_SEQ_STATUS_OFS: begin
          prdata[2:0] <= state_r;
          prdata[4] <= sysclk_hold;
          prdata[5] <= internal_reset;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // A brown-out in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_flag_r <= 1'b0;
    end else if (brownout_event) begin
      brownout_flag_r <= 1'b1; // R7
    end else if (wr_en && pready && paddr == BORS_RESET_CONTROL_REG_OFS) begin
      brownout_flag_r <= pwdata[BORS_BROWNOUT_FLAG_BIT]; // R9
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sel_r <= BORS_OSC_SEL_RST;
      posc_mode_r <= BORS_POSC_MODE_RST;
      powerup_timer_zero_r <= 1'b0;
      irq_mask_r <= BORS_IRQ_MASK_RST;
    end else if (wr_en && pready) begin
      if (paddr == BORS_CONFIG_OFS) begin
        osc_sel_r <= pwdata[BORS_OSC_SEL_LSB +: 3];
        posc_mode_r <= pwdata[BORS_POSC_MODE_LSB +: 2];
        powerup_timer_zero_r <= pwdata[BORS_POWERUP_TIMER_ZERO_BIT];
      end
      if (paddr == BORS_IRQ_MASK_OFS) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 2'b00;
    end else begin
      irq_status_r <= (irq_status_r &
                       ~((wr_en && pready && paddr == BORS_IRQ_STATUS_OFS) ?
                         pwdata[1:0] : 2'b00)) |
                      {release_event, brownout_event};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  assign ost_load = 16'(BORS_OST_CYCLES);
  // A zero power-up delay without a crystal still loads one cycle so the timer reports expiry.
  assign dly_load = (powerup_timer_zero_r && needs_osc(osc_sel_r, posc_mode_r) &&
                     posc_mode_r != BORS_POSC_MODE_EC) ?
                    16'(BORS_FAILSAFE_DELAY_CYC) : // R6
                    (powerup_timer_zero_r ? 16'h0001 : 16'(BORS_POWERUP_DELAY_CYC)); // R5
  assign tim_start = (state_r == S_PULSE) &&
                     (pulse_cnt_r == 8'(BORS_RESET_PULSE_CYC - 1));
  // Release needs both the delay and a usable clock; either may finish last.
  assign release_event = (state_r == S_WAIT) && dly_expired && !dly_running && osc_ok_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_RUN;
      pulse_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        S_RUN: begin
          if (brownout_event) begin
            state_r <= S_PULSE; // R1
            pulse_cnt_r <= 8'h00;
          end
        end
        S_PULSE: begin
          pulse_cnt_r <= pulse_cnt_r + 8'h01;
          if (tim_start) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (brownout_event) begin
            state_r <= S_PULSE;
            pulse_cnt_r <= 8'h00;
          end else if (release_event) begin
            state_r <= S_RUN;
          end
        end
        default: state_r <= S_RUN;
      endcase
    end
  end

  // Clock selection is latched at the start of the sequence.
  // A brown-out that restarts a waiting sequence picks the source again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_sel_r <= BORS_OSC_SEL_RST;
      latched_mode_r <= BORS_POSC_MODE_RST;
      use_osc_r <= 1'b0;
      use_pll_r <= 1'b0;
    end else if (state_r != S_PULSE && brownout_event) begin
      latched_sel_r <= osc_sel_r; // R2
      latched_mode_r <= posc_mode_r; // R2
      use_osc_r <= needs_osc(osc_sel_r, posc_mode_r);
      use_pll_r <= needs_pll(osc_sel_r);
    end
  end

  always_comb begin
    osc_ok_r = (!use_osc_r || (ost_expired && !ost_running)) && // R3
               (!use_pll_r || lock_sync_r[1]); // R4
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset_pulse <= 1'b0;
      internal_reset <= 1'b1;
      sysclk_hold <= 1'b0;
      clk_source <= BORS_OSC_SEL_RST;
      osc_enable <= 1'b0;
      pll_enable <= 1'b0;
    end else begin
      // The pulse drops on the edge at which the timers load, so it stands
      // for exactly the pulse count.
      device_reset_pulse <= (state_r == S_PULSE && !tim_start) ||
                            (state_r != S_PULSE && brownout_event); // R1
      internal_reset <= (state_r != S_RUN && !release_event) || brownout_event; // R5
      sysclk_hold <= (state_r == S_PULSE) ||
                     (state_r == S_WAIT && !osc_ok_r) || brownout_event; // R3
      clk_source <= latched_sel_r;
      osc_enable <= use_osc_r && latched_mode_r != BORS_POSC_MODE_OFF;
      pll_enable <= use_pll_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------------
  bors_timer u_ost (
    .pclk(pclk),
    .presetn(presetn),
    .start(tim_start && use_osc_r),
    .load(ost_load),
    .running(ost_running),
    .expired(ost_expired)
  );

  bors_timer u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .start(tim_start),
    .load(dly_load),
    .running(dly_running),
    .expired(dly_expired)
  );

  // Sleep and idle are observed only; they never mask brown-out detection.
  logic unused_modes;
  assign unused_modes = sleep_mode ^ idle_mode; // R8

endmodule
`default_nettype wire

//--- verilog/bors_timer.sv
// Down-counter used for the start-up, power-up and fail-safe delays.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none
module bors_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic [15:0] load,
  // Status
  output logic running,
  output logic expired
);

  logic [15:0] cnt_r;

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      running <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      running <= 1'b1;
    end else if (running) begin
      if (cnt_r <= 16'h0001) begin
        running <= 1'b0;
      end
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired <= 1'b0;
    end else if (start) begin
      expired <= 1'b0;
    end else if (running && cnt_r <= 16'h0001) begin
      expired <= 1'b1;
    end
  end

endmodule
`default_nettype wire
